// ===== pic_controller.sv
// Operation
// RL1 - Ten request sources, each programmable to one of four levels.
// RL2 - Global enable bit 7 of main enable register gates every source.
// RL3 - Per-source enables; counter array enabled by any of its three enables.
// RL4 - Pending enabled request vectors by long call after current instruction ends.
// RL5 - Flags set even while disabled; disabled flags are simply ignored.
// RL6 - Level is high bit and low bit from two registers, 0..3.
// RL7 - A running routine is not preempted by a lower level request.
// RL8 - Simultaneous requests of different levels: higher level wins.
// RL9 - Equal levels resolved by fixed polling order, position 0 first.
// RL10 - Vector is 0003h plus eight times polling position.
// RL11 - Serial ports and counter array request on OR of their flags.
// RL12 - Return from interrupt ends routine and resumes interrupted program.
// RL13 - After return, one instruction runs before another pending request vectors.
// RL14 - Edge external flags and timer flags clear on vectoring; level follows pin.
// RL15 - Serial port flags are never cleared by vectoring.
// RL16 - Software may set or clear any flag just as hardware does; external flags in level mode follow the pin and ignore writes.
`timescale 1ns/10ps
module pic_controller #(
  parameter int unsigned N = pic_pkg::NUM_SRC
) (
  input  wire logic                        i_ref_clk,
  input  wire logic                        i_resetn,
  input  wire logic                        i_hsel,
  input  wire logic [31:0]                 i_haddr,
  input  wire logic [1:0]                  i_htrans,
  input  wire logic                        i_hwrite,
  input  wire logic [2:0]                  i_hsize,
  input  wire logic [31:0]                 i_hwdata,
  input  wire logic                        i_hready,
  output logic [31:0]                      o_hrdata,
  output logic                             o_hreadyout,
  output logic                             o_hresp,
  input  wire logic                        i_ext_pin_0_n,
  input  wire logic                        i_ext_pin_1_n,
  input  wire pic_pkg::pic_flags_t         i_flag_set,
  input  wire logic                        i_instr_done,
  input  wire logic                        i_return_from_irq_op,
  output pic_pkg::pic_call_t               o_call
);

  localparam int unsigned AW = pic_pkg::ADDR_W;

  logic [7:0]             main_enable_reg_q;
  logic [1:0]             second_enable_reg_q;
  logic [7:0]             level_low_bit_reg_q;
  logic [7:0]             level_high_bit_reg_q;
  logic [1:0]             level_low_bit2_q;
  logic [1:0]             level_high_bit2_q;
  logic [2:0]             counter_array_control_reg_q;
  logic [1:0]             trig_edge_q;
  pic_pkg::pic_flags_t    flags_q;
  pic_pkg::pic_flags_t    flags_d;
  logic [1:0]             pin_prev_n_q;
  logic [3:0]             in_service_q;
  logic                   hold_one_q;
  logic [pic_pkg::IDX_W-1:0] last_idx_q;

  logic                   wr_pend_q;
  logic [AW-1:0]          wr_addr_q;
  logic                   ahb_take;
  logic                   wr_flags;

  logic [N-1:0]           src_req;
  logic [N-1:0]           src_en;
  logic [N-1:0][pic_pkg::LVL_W-1:0] src_level;
  logic                   win_valid;
  logic [pic_pkg::IDX_W-1:0] win_idx;
  logic [pic_pkg::LVL_W-1:0] win_level;
  logic                   cur_active;
  logic [pic_pkg::LVL_W-1:0] cur_level;
  logic                   take_call;

  function automatic logic word_hit(input logic [31:0] addr, input logic [AW-1:0] ofs);
    word_hit = (addr[31:AW] == '0) && (addr[AW-1:0] == ofs);
  endfunction : word_hit

  assign ahb_take = i_hsel && i_hready && (i_htrans == pic_pkg::HTRANS_NONSEQ)
                    && (i_hsize == pic_pkg::HSIZE_WORD);
  assign wr_flags = wr_pend_q && (wr_addr_q == pic_pkg::OFS_FLAGS);

  // Request per source; multi-flag sources request on the OR of their flags.
  always_comb begin
    src_req[0] = flags_q.ext0_request_flag;
    src_req[1] = flags_q.timer0_overflow_flag;
    src_req[2] = flags_q.ext1_request_flag;
    src_req[3] = flags_q.timer1_overflow_flag;
    src_req[4] = flags_q.uart1_rx_done | flags_q.uart1_tx_done; // [RL11]
    src_req[5] = flags_q.adc_done_flag;
    src_req[6] = flags_q.low_voltage_flag;
    src_req[7] = flags_q.counter_overflow_flag | flags_q.module0_match_flag
                 | flags_q.module1_match_flag; // [RL11]
    src_req[8] = flags_q.uart2_rx_done | flags_q.uart2_tx_done; // [RL11]
    src_req[9] = flags_q.serial_periph_done_flag;
  end

  // Enables; a disabled source's flag stays set but is never looked at.
  always_comb begin
    src_en[6:0] = main_enable_reg_q[6:0];
    src_en[7]   = |counter_array_control_reg_q; // [RL3]
    src_en[8]   = second_enable_reg_q[0];
    src_en[9]   = second_enable_reg_q[1];
    if (!main_enable_reg_q[pic_pkg::GLOBAL_EN_BIT]) begin
      src_en = '0; // [RL2] [RL5]
    end
  end

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_level
      if (g < 8) begin : g_main
        assign src_level[g] = {level_high_bit_reg_q[g], level_low_bit_reg_q[g]}; // [RL6]
      end else begin : g_second
        assign src_level[g] = {level_high_bit2_q[g-8], level_low_bit2_q[g-8]}; // [RL6]
      end
    end
  endgenerate

  pic_resolver #(
    .N (N)
  ) u_resolver (
    .i_req   (src_req & src_en),
    .i_level (src_level),
    .o_valid (win_valid),
    .o_idx   (win_idx),
    .o_level (win_level)
  ); // [RL1]

  always_comb begin
    cur_active = |in_service_q;
    cur_level  = '0;
    for (int l = 0; l < 4; l++) begin
      if (in_service_q[l]) begin
        cur_level = pic_pkg::LVL_W'(l);
      end
    end
  end

  // Only a strictly higher level may nest; equal or lower waits for return.
  // No call is taken while one is being issued, so the call pulse never stretches.
  assign take_call = i_instr_done && win_valid && !hold_one_q && !o_call.long_call_op
                     && (!cur_active || (win_level > cur_level)); // [RL4] [RL7]

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_call      <= '0;
      last_idx_q  <= '0;
    end else begin
      o_call.long_call_op <= take_call; // [RL4]
      if (take_call) begin
        o_call.vector <= pic_pkg::VEC_BASE
                         + (pic_pkg::VEC_W'(win_idx) << pic_pkg::VEC_SHIFT); // [RL10]
        last_idx_q    <= win_idx;
      end
    end
  end

  // In-service levels; return clears the highest active one.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      in_service_q <= '0;
    end else if (take_call) begin
      in_service_q[win_level] <= 1'b1;
    end else if (i_return_from_irq_op && cur_active) begin
      in_service_q[cur_level] <= 1'b0; // [RL12]
    end
  end

  // One instruction after a return completes before any new vectoring.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      hold_one_q <= 1'b0;
    end else if (i_return_from_irq_op) begin
      hold_one_q <= 1'b1; // [RL13]
    end else if (i_instr_done) begin
      hold_one_q <= 1'b0; // [RL13]
    end
  end

  // Flags: software write first, then vectoring clears, then hardware sets,
  // so an event coinciding with a clear is never lost.
  always_comb begin
    flags_d = flags_q;
    if (wr_flags) begin
      flags_d = pic_pkg::pic_flags_t'(i_hwdata[pic_pkg::NUM_FLAGS-1:0]); // [RL16]
    end
    if (take_call) begin
      if (win_idx == pic_pkg::IDX_W'(0) && trig_edge_q[0]) begin
        flags_d.ext0_request_flag = 1'b0; // [RL14]
      end
      if (win_idx == pic_pkg::IDX_W'(1)) begin
        flags_d.timer0_overflow_flag = 1'b0; // [RL14]
      end
      if (win_idx == pic_pkg::IDX_W'(2) && trig_edge_q[1]) begin
        flags_d.ext1_request_flag = 1'b0; // [RL14]
      end
      if (win_idx == pic_pkg::IDX_W'(3)) begin
        flags_d.timer1_overflow_flag = 1'b0; // [RL14]
      end
      // Serial, converter, voltage, counter and peripheral flags stay set. [RL15]
    end
    flags_d = flags_d | i_flag_set; // [RL5]
    if (trig_edge_q[0]) begin
      flags_d.ext0_request_flag = flags_d.ext0_request_flag
                                  | (pin_prev_n_q[0] & ~i_ext_pin_0_n);
    end else begin
      flags_d.ext0_request_flag = ~i_ext_pin_0_n; // [RL14]
    end
    if (trig_edge_q[1]) begin
      flags_d.ext1_request_flag = flags_d.ext1_request_flag
                                  | (pin_prev_n_q[1] & ~i_ext_pin_1_n);
    end else begin
      flags_d.ext1_request_flag = ~i_ext_pin_1_n; // [RL14]
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      flags_q      <= '0;
      pin_prev_n_q <= 2'b11;
    end else begin
      flags_q      <= flags_d;
      pin_prev_n_q <= {i_ext_pin_1_n, i_ext_pin_0_n};
    end
  end

  // Bus address phase capture; data are written in the following data phase.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
    end else begin
      wr_pend_q <= ahb_take && i_hwrite && (i_haddr[31:AW] == '0);
      wr_addr_q <= i_haddr[AW-1:0];
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      main_enable_reg_q           <= pic_pkg::RST_BYTE;
      second_enable_reg_q         <= '0;
      level_low_bit_reg_q         <= pic_pkg::RST_BYTE;
      level_high_bit_reg_q        <= pic_pkg::RST_BYTE;
      level_low_bit2_q            <= '0;
      level_high_bit2_q           <= '0;
      counter_array_control_reg_q <= '0;
      trig_edge_q                 <= '0;
    end else if (wr_pend_q) begin
      unique case (wr_addr_q)
        pic_pkg::OFS_MAIN_EN:   main_enable_reg_q           <= i_hwdata[7:0];
        pic_pkg::OFS_SECOND_EN: second_enable_reg_q         <= i_hwdata[1:0];
        pic_pkg::OFS_LVL_LO:    level_low_bit_reg_q         <= i_hwdata[7:0];
        pic_pkg::OFS_LVL_HI:    level_high_bit_reg_q        <= i_hwdata[7:0];
        pic_pkg::OFS_LVL_LO2:   level_low_bit2_q            <= i_hwdata[1:0];
        pic_pkg::OFS_LVL_HI2:   level_high_bit2_q           <= i_hwdata[1:0];
        pic_pkg::OFS_CNT_EN:    counter_array_control_reg_q <= i_hwdata[2:0];
        pic_pkg::OFS_TRIG:      trig_edge_q                 <= i_hwdata[1:0];
        default: ;
      endcase
    end
  end

  // Read data is registered at the address phase so it stands for the
  // whole data phase with no wait state.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_hrdata    <= '0;
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
    end else begin
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
      if (ahb_take && !i_hwrite) begin
        o_hrdata <= '0;
        if (word_hit(i_haddr, pic_pkg::OFS_MAIN_EN)) begin
          o_hrdata[7:0] <= main_enable_reg_q;
        end
        if (word_hit(i_haddr, pic_pkg::OFS_SECOND_EN)) begin
          o_hrdata[1:0] <= second_enable_reg_q;
        end
        if (word_hit(i_haddr, pic_pkg::OFS_LVL_LO)) begin
          o_hrdata[7:0] <= level_low_bit_reg_q;
        end
        if (word_hit(i_haddr, pic_pkg::OFS_LVL_HI)) begin
          o_hrdata[7:0] <= level_high_bit_reg_q;
        end
        if (word_hit(i_haddr, pic_pkg::OFS_LVL_LO2)) begin
          o_hrdata[1:0] <= level_low_bit2_q;
        end
        if (word_hit(i_haddr, pic_pkg::OFS_LVL_HI2)) begin
          o_hrdata[1:0] <= level_high_bit2_q;
        end
        if (word_hit(i_haddr, pic_pkg::OFS_CNT_EN)) begin
          o_hrdata[2:0] <= counter_array_control_reg_q;
        end
        if (word_hit(i_haddr, pic_pkg::OFS_FLAGS)) begin
          o_hrdata[pic_pkg::NUM_FLAGS-1:0] <= flags_q;
        end
        if (word_hit(i_haddr, pic_pkg::OFS_TRIG)) begin
          o_hrdata[1:0] <= trig_edge_q;
        end
        if (word_hit(i_haddr, pic_pkg::OFS_STATUS)) begin
          o_hrdata[13:0] <= {hold_one_q, win_valid, win_idx, last_idx_q, in_service_q};
        end
      end
    end
  end

endmodule : pic_controller

// ===== pic_pkg.sv
package pic_pkg;

  localparam int unsigned NUM_SRC     = 10;
  localparam int unsigned LVL_W       = 2;
  localparam int unsigned IDX_W       = 4;
  localparam int unsigned VEC_W       = 16;
  localparam int unsigned ADDR_W      = 8;

  localparam logic [VEC_W-1:0] VEC_BASE  = 16'h0003;
  localparam int unsigned      VEC_SHIFT = 3;

  localparam logic [ADDR_W-1:0] OFS_MAIN_EN   = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_SECOND_EN = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_LVL_LO    = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_LVL_HI    = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_LVL_LO2   = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_LVL_HI2   = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_CNT_EN    = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_FLAGS     = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_TRIG      = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_STATUS    = 8'h24;

  localparam int unsigned GLOBAL_EN_BIT = 7;
  localparam logic [7:0]  RST_BYTE      = 8'h00;
  localparam int unsigned NUM_FLAGS     = 14;

  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic [2:0] HSIZE_WORD    = 3'b010;

  // Bit order of this struct is the bit order of the flags register, lsb last.
  typedef struct packed {
    logic serial_periph_done_flag;
    logic uart2_tx_done;
    logic uart2_rx_done;
    logic module1_match_flag;
    logic module0_match_flag;
    logic counter_overflow_flag;
    logic low_voltage_flag;
    logic adc_done_flag;
    logic uart1_tx_done;
    logic uart1_rx_done;
    logic timer1_overflow_flag;
    logic ext1_request_flag;
    logic timer0_overflow_flag;
    logic ext0_request_flag;
  } pic_flags_t;

  typedef struct packed {
    logic [VEC_W-1:0] vector;
    logic             long_call_op;
  } pic_call_t;

endpackage : pic_pkg

// ===== pic_resolver.sv
`timescale 1ns/10ps
module pic_resolver #(
  parameter int unsigned N = pic_pkg::NUM_SRC
) (
  input  wire logic [N-1:0]                 i_req,
  input  wire logic [N-1:0][pic_pkg::LVL_W-1:0] i_level,
  output logic                              o_valid,
  output logic [pic_pkg::IDX_W-1:0]         o_idx,
  output logic [pic_pkg::LVL_W-1:0]         o_level
);

  // Scan from the lowest polling position upward; a strictly higher level
  // displaces the winner, so ties go to the earlier position.
  always_comb begin
    o_valid = 1'b0;
    o_idx   = '0;
    o_level = '0;
    for (int i = 0; i < N; i++) begin
      if (i_req[i] && (!o_valid || (i_level[i] > o_level))) begin // [RL8] [RL9]
        o_valid = 1'b1;
        o_idx   = pic_pkg::IDX_W'(i);
        o_level = i_level[i];
      end
    end
  end

endmodule : pic_resolver

// ===== pic_controller_sva.sv
`timescale 1ns/10ps
module pic_controller_chk (
  input wire logic               i_ref_clk,
  input wire logic               i_resetn,
  input wire logic               i_hsel,
  input wire logic [31:0]        i_haddr,
  input wire logic [1:0]         i_htrans,
  input wire logic               i_hwrite,
  input wire logic [2:0]         i_hsize,
  input wire logic [31:0]        i_hwdata,
  input wire logic               i_hready,
  input wire logic [31:0]        o_hrdata,
  input wire logic               o_hreadyout,
  input wire logic               o_hresp,
  input wire logic               i_instr_done,
  input wire logic               i_return_from_irq_op,
  input wire pic_pkg::pic_call_t o_call
);
  logic tk;
  logic wr_main_q;
  logic glob_q;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);
  assign tk = i_hsel && i_hready && i_htrans == pic_pkg::HTRANS_NONSEQ
              && i_hsize == pic_pkg::HSIZE_WORD;
  // A shadow of the global enable lets the gate be judged from the pins alone.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wr_main_q <= 1'b0;
      glob_q    <= 1'b0;
    end else begin
      wr_main_q <= tk && i_hwrite && i_haddr == {24'h0, pic_pkg::OFS_MAIN_EN};
      if (wr_main_q) glob_q <= i_hwdata[pic_pkg::GLOBAL_EN_BIT];
    end
  end
  sequence s_ret_done;
    i_return_from_irq_op ##1 i_instr_done;
  endsequence
  sequence s_accept;
    i_instr_done ##1 o_call.long_call_op;
  endsequence
  AST_CALL_PULSE: assert property (o_call.long_call_op |=> !o_call.long_call_op)
    else $error("long call pulse lasts more than one cycle");
  AST_CALL_CAUSE: assert property (o_call.long_call_op |-> $past(i_instr_done))
    else $error("long call without a finished instruction");
  AST_VEC_MAP: assert property (o_call.long_call_op |->
    o_call.vector[2:0] == 3'h3 && o_call.vector[15:3] <= 13'h9)
    else $error("vector outside the table");
  AST_VEC_HOLD: assert property (!o_call.long_call_op |-> $stable(o_call.vector))
    else $error("vector changed without a call");
  AST_GLOBAL_GATE: assert property (i_instr_done && !glob_q |=> !o_call.long_call_op)
    else $error("call while globally disabled");
  AST_HOLD_ONE: assert property (s_ret_done |=> !o_call.long_call_op)
    else $error("no instruction ran after return");
  AST_BUS_OKAY: assert property (o_hreadyout && !o_hresp)
    else $error("bus not ready or not okay");
  AST_UNMAPPED_RD: assert property (tk && !i_hwrite && i_haddr[7:0] > pic_pkg::OFS_STATUS
    |=> o_hrdata == 32'h0)
    else $error("unmapped read not zero");
  COV_ACCEPT: cover property (s_accept);
endmodule : pic_controller_chk

// ===== pic_core_model.sv
`timescale 1ns/10ps
module pic_core_model (
  input  wire logic               i_ref_clk,
  input  wire logic               i_resetn,
  input  wire logic               i_run,
  input  wire logic [1:0]         i_gap,
  input  wire logic [3:0]         i_isr_len,
  input  wire pic_pkg::pic_call_t i_call,
  output logic                    o_instr_done,
  output logic                    o_ret,
  output logic                    o_idle
);
  logic [1:0] cnt_q;
  logic [3:0] depth_q;
  logic [3:0] left_q;
  assign o_idle = depth_q == 4'h0;
  // A return is an instruction slot of its own, never shared with a finished instruction.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_q        <= 2'h0;
      depth_q      <= 4'h0;
      left_q       <= 4'h0;
      o_instr_done <= 1'b0;
      o_ret        <= 1'b0;
    end else begin
      o_instr_done <= 1'b0;
      o_ret        <= 1'b0;
      cnt_q        <= cnt_q + 2'h1;
      if (i_call.long_call_op) begin
        depth_q <= depth_q + 4'h1;
        left_q  <= i_isr_len;
      end else if (i_run && cnt_q >= i_gap) begin
        cnt_q <= 2'h0;
        if (depth_q != 4'h0 && left_q == 4'h0) begin
          o_ret   <= 1'b1;
          depth_q <= depth_q - 4'h1;
          left_q  <= i_isr_len;
        end else begin
          o_instr_done <= 1'b1;
          if (depth_q != 4'h0) left_q <= left_q - 4'h1;
        end
      end
    end
  end
endmodule : pic_core_model

// ===== priority_interrupt_controller_tb.sv
`timescale 1ns/10ps
module priority_interrupt_controller_tb;
  logic                clk = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic                p0_n = 1'b1, p1_n = 1'b1, run = 1'b0;
  logic [31:0]         haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0]          htrans = 2'h0, gap = 2'h0;
  logic [3:0]          ilen = 4'h8;
  logic                hready, hresp, idone, iret, idle;
  pic_pkg::pic_flags_t fset = '0;
  pic_pkg::pic_call_t  call;
  logic [15:0]         expq[$];
  int                  num_errors = 0, n_compared = 0, ncalls = 0;
  int                  fb[10] = '{0, 1, 2, 3, 4, 6, 7, 8, 11, 13};
  int                  nb[10] = '{1, 1, 1, 1, 2, 1, 1, 3, 2, 1};
  always #12.5 clk = ~clk;
  pic_controller dut (.i_ref_clk(clk), .i_resetn(rstn), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(pic_pkg::HSIZE_WORD), .i_hwdata(hwdata),
    .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
    .i_ext_pin_0_n(p0_n), .i_ext_pin_1_n(p1_n), .i_flag_set(fset), .i_instr_done(idone),
    .i_return_from_irq_op(iret), .o_call(call));
  pic_core_model core (.i_ref_clk(clk), .i_resetn(rstn), .i_run(run), .i_gap(gap),
    .i_isr_len(ilen), .i_call(call), .o_instr_done(idone), .o_ret(iret), .o_idle(idle));
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string nm);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd,
                     output logic [31:0] rd);
    int k;
    k = 0;
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= pic_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    do begin @(posedge clk); k++; end while (hready !== 1'b1 && k < 20);
    htrans <= 2'h0;
    hwdata <= wd;
    do begin @(posedge clk); k++; end while (hready !== 1'b1 && k < 40);
    rd = hrdata;
    if (k >= 40) begin num_errors++; end_of_test(); end
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] v;
    bus(a, 1'b1, d, v);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    bus(a, 1'b0, 32'h0, v);
    chk(v, e, "register read");
  endtask : rdc
  task automatic pulse(input pic_pkg::pic_flags_t f);
    fset <= f;
    @(posedge clk);
    fset <= '0;
  endtask : pulse
  task automatic wait_for(input int n, input logic need_idle);
    int k;
    for (k = 0; k < 500 && (ncalls < n || (need_idle && idle !== 1'b1)); k++) @(posedge clk);
    if (k == 500) begin num_errors++; end_of_test(); end
  endtask : wait_for
  always @(posedge clk) begin
    logic [15:0] e;
    if (call.long_call_op === 1'b1) begin
      ncalls++;
      e = (expq.size() > 0) ? expq.pop_front() : 16'hxxxx;
      chk({16'h0, call.vector}, {16'h0, e}, "call vector");
    end
  end
  initial begin
    int b;
    int n;
    void'($urandom(71));
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    for (int a = 0; a <= 'h28; a += 4) rdc(8'(a), 32'h0);
    wr(8'h28, 32'hffffffff);
    rdc(8'h28, 32'h0);
    $display("test reset done");
    wr(pic_pkg::OFS_MAIN_EN, 32'h7f);
    run <= 1'b1;
    pulse(14'h2);
    repeat (20) @(posedge clk);
    rdc(pic_pkg::OFS_FLAGS, 32'h2);
    p0_n <= 1'b0;
    @(posedge clk);
    rdc(pic_pkg::OFS_FLAGS, 32'h3);
    p0_n <= 1'b1;
    expq.push_back(pic_pkg::VEC_BASE + 16'h8);
    wr(pic_pkg::OFS_MAIN_EN, 32'hff);
    wait_for(1, 1'b1);
    rdc(pic_pkg::OFS_FLAGS, 32'h0);
    $display("test global gate done");
    wr(pic_pkg::OFS_SECOND_EN, 32'h3);
    wr(pic_pkg::OFS_TRIG, 32'h3);
    for (int i = 0; i < 10; i++) begin
      b = fb[i] + int'($urandom % nb[i]);
      wr(pic_pkg::OFS_CNT_EN, 32'h1 << ($urandom % 3));
      gap <= 2'($urandom % 4);
      expq.push_back(pic_pkg::VEC_BASE + 16'(i * 8));
      n = ncalls;
      if (i == 0 || i == 2) begin
        {p1_n, p0_n} <= (i == 0) ? 2'b10 : 2'b01;
        @(posedge clk);
        {p1_n, p0_n} <= 2'b11;
      end else pulse(14'h1 << b);
      wait_for(n + 1, 1'b0);
      // The routine is frozen so that sticky flags cannot call again before they are cleared.
      run <= 1'b0;
      rdc(pic_pkg::OFS_FLAGS, (i < 4) ? 32'h0 : 32'h1 << b);
      wr(pic_pkg::OFS_FLAGS, 32'h0);
      run <= 1'b1;
      wait_for(n + 1, 1'b1);
    end
    $display("test sources done");
    gap <= 2'h0;
    run <= 1'b0;
    wr(pic_pkg::OFS_LVL_LO, 32'h0a);
    wr(pic_pkg::OFS_LVL_HI, 32'h0c);
    for (int r = 0; r < 2; r++) begin
      n = ncalls;
      pulse(14'h0f);
      for (int j = 0; j < 4; j++)
        expq.push_back(pic_pkg::VEC_BASE + 16'(((r == 1) ? j : 3 - j) * 8));
      run <= 1'b1;
      wait_for(n + 4, 1'b1);
      run <= 1'b0;
      wr(pic_pkg::OFS_LVL_LO, 32'h0);
      wr(pic_pkg::OFS_LVL_HI, 32'h0);
    end
    $display("test levels done");
    ilen <= 4'hc;
    wr(pic_pkg::OFS_LVL_LO, 32'h08);
    wr(pic_pkg::OFS_LVL_HI, 32'h08);
    run <= 1'b1;
    for (int r = 0; r < 2; r++) begin
      n = ncalls;
      expq.push_back(pic_pkg::VEC_BASE + ((r == 1) ? 16'h18 : 16'h8));
      pulse((r == 1) ? 14'h8 : 14'h2);
      wait_for(n + 1, 1'b0);
      if (r == 0) expq.push_back(pic_pkg::VEC_BASE + 16'h18);
      pulse((r == 1) ? 14'h2 : 14'h8);
      repeat (4) @(posedge clk);
      chk(32'(ncalls), 32'(n + 2 - r), "calls in routine");
      if (r == 1) expq.push_back(pic_pkg::VEC_BASE + 16'h8);
      wait_for(n + 2, 1'b1);
    end
    $display("test nesting done");
    chk(32'(expq.size()), 32'h0, "calls left");
    end_of_test();
  end
endmodule : priority_interrupt_controller_tb
bind pic_controller pic_controller_chk u_chk (.*);
